// ---- rtl/mse_bank.sv ----
`default_nettype none
// Functional notes
// - axis2 bit0 follows warning threshold exceeded
// - axis2 bits1,2 follow hardware limits
// - axis2 bits3,4 origin search, feedhold
// - axis2 bit5 following error hard limit
// - axis2 bits6,7 software forward, reverse limits
// - axis3 same flags in bits 8-15
// - word7 bits0-4 per-task program error
// - word7 bit5 low battery
// - word7 bit7 transfer failure
// - word7 bits8-15 mirror indicator mode
// - transfer input words at offsets 8,9
// - both copies agree each I/O refresh
// - program reaches words only via fetch/post
// - host block access without unit program
// - fetch/post performed at next refresh
// - output words taken each refresh; fetch copies
// - post copies variables, delivered next refresh
// - block transfer at most 128 words
module mse_bank
   import mse_pkg::*;
(
   input  wire logic             clk_sys,
   input  wire logic             rst,
   input  wire logic             ce,
   // unit-side status sources
   input  wire mse_pkg::mse_axis_t axis2,
   input  wire mse_pkg::mse_axis_t axis3,
   input  wire logic [4:0]       task_error,
   input  wire logic             battery_low,
   input  wire logic [7:0]       indicator_mode,
   // unit program commands
   input  wire logic             unit_fetch_command,
   input  wire logic             unit_post_command,
   input  wire logic [7:0]       fetch_var_addr,
   input  wire logic [7:0]       post_var_addr,
   output logic                  unit_cmd_pending,
   // host I/O refresh
   input  wire logic             io_refresh,
   input  wire logic [15:0]      host_out_first,
   input  wire logic [15:0]      host_out_second,
   output logic [15:0]           axis23_word,
   output logic [15:0]           task_unit_word,
   output logic [15:0]           in_first_word,
   output logic [15:0]           in_second_word,
   // host direct block access
   input  wire logic             host_block_read,
   input  wire logic             host_block_write,
   input  wire logic [7:0]       block_start,
   input  wire logic [7:0]       block_count,
   input  wire logic             block_wvalid,
   input  wire logic [15:0]      block_wdata,
   output logic                  block_busy,
   output logic                  block_rvalid,
   output logic [15:0]           block_rdata,
   output logic                  xfer_error
);
   import mse_pkg::*;

   // ------------------------------------------------------------
   // status words sampled at each refresh
   // ------------------------------------------------------------
   logic [15:0] next_axis23_word;
   logic [15:0] next_task_unit_word;
   logic [15:0] live_axis23;
   logic [15:0] live_task_unit;

   genvar gi;
   generate
      for (gi = 0; gi < AXIS_FLAGS; gi++) begin : g_axis
         assign live_axis23[gi]             = axis2[gi];
         assign live_axis23[AXIS3_LSB + gi] = axis3[gi];
      end
   endgenerate

   always_comb begin
      live_task_unit                         = WORD_RESET;
      live_task_unit[TASKS-1:0]              = task_error;
      live_task_unit[BIT_LOW_BATT]           = battery_low;
      live_task_unit[BIT_UNUSED]             = 1'b0;
      live_task_unit[BIT_XFER_ERR]           = xfer_error;
      live_task_unit[IND_LSB +: 8]           = indicator_mode;
   end

   always_comb begin
      next_axis23_word    = axis23_word;
      next_task_unit_word = task_unit_word;
      if (io_refresh) begin
         next_axis23_word    = live_axis23;
         next_task_unit_word = live_task_unit;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         axis23_word    <= WORD_RESET;
         task_unit_word <= WORD_RESET;
      end else if (ce) begin
         axis23_word    <= next_axis23_word;
         task_unit_word <= next_task_unit_word;
      end
   end

   // ------------------------------------------------------------
   // transfer words and unit commands
   // ------------------------------------------------------------
   logic [15:0] out_copy [2];
   logic [15:0] in_copy  [2];
   logic [15:0] next_out_copy [2];
   logic [15:0] next_in_copy  [2];
   logic [15:0] next_in_first_word;
   logic [15:0] next_in_second_word;
   logic        fetch_pend;
   logic        post_pend;
   logic        next_fetch_pend;
   logic        next_post_pend;
   logic [7:0]  fetch_addr;
   logic [7:0]  post_addr;
   logic [7:0]  next_fetch_addr;
   logic [7:0]  next_post_addr;
   logic [1:0]  seq;
   logic [1:0]  next_seq;
   logic        post_rd_q;
   logic        next_post_rd_q;
   logic        post_cap0;
   logic        post_cap1;

   mse_mem_req_t unit_req;
   logic [15:0]  unit_rdata;

   // unit sequencer: one word per cycle after the refresh
   // seq 1,2 = fetch words 0,1 ; seq 3 requests post reads
   always_comb begin
      next_out_copy = out_copy;
      next_in_copy  = in_copy;
      next_in_first_word  = in_first_word;
      next_in_second_word = in_second_word;
      next_fetch_pend = fetch_pend | unit_fetch_command;
      next_post_pend  = post_pend  | unit_post_command;
      next_fetch_addr = unit_fetch_command ? fetch_var_addr : fetch_addr;
      next_post_addr  = unit_post_command  ? post_var_addr  : post_addr;
      next_seq = seq;
      unit_req = '0;
      if (io_refresh) begin
         next_out_copy[0]    = host_out_first;
         next_out_copy[1]    = host_out_second;
         next_in_first_word  = in_copy[0];
         next_in_second_word = in_copy[1];
         if (fetch_pend || post_pend) begin
            next_seq = 2'h1;
         end
      end else begin
         case (seq)
            2'h1: begin
               if (fetch_pend) begin
                  unit_req = '{req: 1'b1, wr: 1'b1, addr: fetch_addr, wdata: out_copy[0]};
               end
               next_seq = 2'h2;
            end
            2'h2: begin
               if (fetch_pend) begin
                  unit_req = '{req: 1'b1, wr: 1'b1, addr: 8'(fetch_addr + 8'h01), wdata: out_copy[1]};
                  next_fetch_pend = unit_fetch_command;
               end
               next_seq = 2'h3;
            end
            2'h3: begin
               if (post_pend) begin
                  unit_req = '{req: 1'b1, wr: 1'b0, addr: (post_rd_q ? 8'(post_addr + 8'h01) : post_addr),
                               wdata: 16'h0000};
               end
               if (!post_pend || post_rd_q) begin
                  next_seq = 2'h0;
               end
            end
            default: next_seq = 2'h0;
         endcase
      end
      // read data lands one cycle after each post read request
      if (post_cap0) begin
         next_in_copy[0] = unit_rdata;
      end
      if (post_cap1) begin
         next_in_copy[1] = unit_rdata;
         next_post_pend  = unit_post_command;
      end
   end

   always_comb begin
      next_post_rd_q = post_rd_q;
      if (seq == 2'h3 && post_pend && !io_refresh) begin
         next_post_rd_q = !post_rd_q;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         out_copy       <= '{default: 16'h0000};
         in_copy        <= '{default: 16'h0000};
         in_first_word  <= WORD_RESET;
         in_second_word <= WORD_RESET;
         fetch_pend     <= 1'b0;
         post_pend      <= 1'b0;
         fetch_addr     <= 8'h00;
         post_addr      <= 8'h00;
         seq            <= 2'h0;
         post_rd_q      <= 1'b0;
         post_cap0      <= 1'b0;
         post_cap1      <= 1'b0;
      end else if (ce) begin
         out_copy       <= next_out_copy;
         in_copy        <= next_in_copy;
         in_first_word  <= next_in_first_word;
         in_second_word <= next_in_second_word;
         fetch_pend     <= next_fetch_pend;
         post_pend      <= next_post_pend;
         fetch_addr     <= next_fetch_addr;
         post_addr      <= next_post_addr;
         seq            <= next_seq;
         post_rd_q      <= next_post_rd_q;
         post_cap0      <= unit_req.req && !unit_req.wr && !post_rd_q;
         post_cap1      <= unit_req.req && !unit_req.wr && post_rd_q;
      end
   end

   assign unit_cmd_pending = fetch_pend | post_pend;

   // ------------------------------------------------------------
   // host block transfers (no unit program involved)
   // ------------------------------------------------------------
   mse_blk_state_t blk_state;
   mse_blk_state_t next_blk_state;
   logic        blk_wr;
   logic        next_blk_wr;
   logic [7:0]  blk_addr;
   logic [7:0]  next_blk_addr;
   logic [7:0]  blk_left;
   logic [7:0]  next_blk_left;
   logic        next_xfer_error;
   logic        rd_issued;
   mse_mem_req_t host_req;
   logic [15:0]  host_rdata;

   always_comb begin
      next_blk_state  = blk_state;
      next_blk_wr     = blk_wr;
      next_blk_addr   = blk_addr;
      next_blk_left   = blk_left;
      next_xfer_error = xfer_error;
      host_req        = '0;
      case (blk_state)
         ST_IDLE: begin
            if (host_block_read || host_block_write) begin
               if (block_count == 8'h00 || block_count > BLOCK_MAX
                   || (host_block_read && host_block_write)) begin
                  next_xfer_error = 1'b1;
               end else begin
                  next_xfer_error = 1'b0;
                  next_blk_state  = ST_BLOCK;
                  next_blk_wr     = host_block_write;
                  next_blk_addr   = block_start;
                  next_blk_left   = block_count;
               end
            end
         end
         ST_BLOCK: begin
            if (!blk_wr || block_wvalid) begin
               host_req = '{req: 1'b1, wr: blk_wr, addr: blk_addr, wdata: block_wdata};
               next_blk_addr = 8'(blk_addr + 8'h01);
               next_blk_left = 8'(blk_left - 8'h01);
               if (blk_left == 8'h01) begin
                  next_blk_state = ST_DONE;
               end
            end
         end
         ST_DONE: next_blk_state = ST_IDLE;
         default: next_blk_state = ST_IDLE;
      endcase
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         blk_state    <= ST_IDLE;
         blk_wr       <= 1'b0;
         blk_addr     <= 8'h00;
         blk_left     <= 8'h00;
         xfer_error   <= 1'b0;
         rd_issued    <= 1'b0;
         block_rvalid <= 1'b0;
         block_rdata  <= 16'h0000;
      end else if (ce) begin
         blk_state    <= next_blk_state;
         blk_wr       <= next_blk_wr;
         blk_addr     <= next_blk_addr;
         blk_left     <= next_blk_left;
         xfer_error   <= next_xfer_error;
         rd_issued    <= host_req.req && !host_req.wr;
         block_rvalid <= rd_issued;
         block_rdata  <= host_rdata;
      end
   end

   assign block_busy = (blk_state != ST_IDLE);

   mse_var_mem u_mem (
      .clk_sys (clk_sys),
      .ce      (ce),
      .port_a  (host_req),
      .rdata_a (host_rdata),
      .port_b  (unit_req),
      .rdata_b (unit_rdata)
   );

   // ------------------------------------------------------------
   // checks
   // ------------------------------------------------------------
   axis_sample_a: assert property (@(posedge clk_sys) disable iff (rst)
      (ce && io_refresh) |=> axis23_word == {$past(axis3), $past(axis2)})
      else $error("axis word not sampled at refresh");
   task_sample_a: assert property (@(posedge clk_sys) disable iff (rst)
      (ce && io_refresh) |=> task_unit_word[4:0] == $past(task_error)
                             && task_unit_word[15:8] == $past(indicator_mode))
      else $error("task word not sampled at refresh");
   unused_zero_a: assert property (@(posedge clk_sys) disable iff (rst)
      !task_unit_word[BIT_UNUSED]) else $error("unused bit set");
   batt_bit_a: assert property (@(posedge clk_sys) disable iff (rst)
      (ce && io_refresh) |=> task_unit_word[BIT_LOW_BATT] == $past(battery_low))
      else $error("battery bit wrong");
   out_copy_a: assert property (@(posedge clk_sys) disable iff (rst)
      (ce && io_refresh) |=> out_copy[0] == $past(host_out_first) && out_copy[1] == $past(host_out_second))
      else $error("output words not taken");
   in_deliver_a: assert property (@(posedge clk_sys) disable iff (rst)
      (ce && io_refresh) |=> in_first_word == $past(in_copy[0]) && in_second_word == $past(in_copy[1]))
      else $error("input words not delivered");
   cmd_start_a: assert property (@(posedge clk_sys) disable iff (rst)
      (ce && io_refresh && (fetch_pend || post_pend)) |=> seq == 2'h1)
      else $error("command not started at refresh");
   block_limit_a: assert property (@(posedge clk_sys) disable iff (rst)
      (ce && blk_state == ST_IDLE && (host_block_read || host_block_write) && block_count > BLOCK_MAX)
      |=> xfer_error && blk_state == ST_IDLE) else $error("oversize block accepted");
   block_run_a: assert property (@(posedge clk_sys) disable iff (rst)
      (ce && blk_state == ST_IDLE && host_block_read && !host_block_write
       && block_count == 8'h01)
      |=> blk_state == ST_BLOCK ##1 blk_state == ST_DONE ##1 blk_state == ST_IDLE)
      else $error("block read did not run");
endmodule
`default_nettype wire

// ---- rtl/mse_pkg.sv ----
`default_nettype none
package mse_pkg;
   // ------------------------------------------------------------
   // word offsets of the host-visible bank
   // ------------------------------------------------------------
   localparam logic [3:0] OFS_OUT_FIRST  = 4'h0;
   localparam logic [3:0] OFS_OUT_SECOND = 4'h1;
   localparam logic [3:0] OFS_AXIS23     = 4'h6;
   localparam logic [3:0] OFS_TASK_UNIT  = 4'h7;
   localparam logic [3:0] OFS_IN_FIRST   = 4'h8;
   localparam logic [3:0] OFS_IN_SECOND  = 4'h9;

   // ------------------------------------------------------------
   // field layout
   // ------------------------------------------------------------
   localparam int AXIS_FLAGS      = 8;
   localparam int AXIS3_LSB       = 8;
   localparam int TASKS           = 5;
   localparam int BIT_LOW_BATT    = 5;
   localparam int BIT_UNUSED      = 6;
   localparam int BIT_XFER_ERR    = 7;
   localparam int IND_LSB         = 8;
   localparam logic [15:0] WORD_RESET = 16'h0000;

   // ------------------------------------------------------------
   // direct block access
   // ------------------------------------------------------------
   localparam int VAR_DEPTH       = 256;
   localparam int VAR_AW          = 8;
   localparam logic [7:0] BLOCK_MAX = 8'h80;

   typedef struct packed {
      logic sw_rev_lim;
      logic sw_fwd_lim;
      logic ferr_limit;
      logic feedhold;
      logic origin_search;
      logic hw_rev_lim;
      logic hw_fwd_lim;
      logic ferr_warn;
   } mse_axis_t;

   typedef struct packed {
      logic            req;
      logic            wr;
      logic [VAR_AW-1:0] addr;
      logic [15:0]     wdata;
   } mse_mem_req_t;

   typedef enum logic [1:0] {
      ST_IDLE   = 2'b00,
      ST_BLOCK  = 2'b01,
      ST_DONE   = 2'b10
   } mse_blk_state_t;
endpackage
`default_nettype wire

// ---- rtl/mse_var_mem.sv ----
`default_nettype none
module mse_var_mem
   import mse_pkg::*;
(
   input  wire logic         clk_sys,
   input  wire logic         ce,
   input  wire mse_pkg::mse_mem_req_t port_a,
   output logic [15:0]       rdata_a,
   input  wire mse_pkg::mse_mem_req_t port_b,
   output logic [15:0]       rdata_b
);
   logic [15:0] mem [VAR_DEPTH];

   // port a wins if both write the same word in one cycle
   always_ff @(posedge clk_sys) begin
      if (ce) begin
         if (port_b.req && port_b.wr) begin
            mem[port_b.addr] <= port_b.wdata;
         end
         if (port_a.req && port_a.wr) begin
            mem[port_a.addr] <= port_a.wdata;
         end
         if (port_a.req) begin
            rdata_a <= mem[port_a.addr];
         end
         if (port_b.req) begin
            rdata_b <= mem[port_b.addr];
         end
      end
   end
endmodule
`default_nettype wire

// ---- tb/mse_host_model.sv ----
`default_nettype none
module mse_host_model #(
   parameter int REFRESH_GAP = 8
) (
   input  wire logic        clk_sys,
   input  wire logic        rst,
   output logic             io_refresh,
   input  wire logic [15:0] in_first_word,
   input  wire logic [15:0] in_second_word,
   output logic [15:0]      host_in_first,
   output logic [15:0]      host_in_second
);
   timeunit 1ns;
   timeprecision 1ps;

   int   gap_cnt;
   logic refresh_d;

   initial begin
      io_refresh     = 1'b0;
      gap_cnt        = 0;
      refresh_d      = 1'b0;
      host_in_first  = 16'h0000;
      host_in_second = 16'h0000;
   end

   // ------------------------------------------------------------
   // refresh pacing
   // ------------------------------------------------------------
   // the device needs at least six cycles between refreshes
   always @(negedge clk_sys) begin
      if (rst) begin
         gap_cnt    <= 0;
         io_refresh <= 1'b0;
      end else begin
         gap_cnt    <= (gap_cnt == REFRESH_GAP - 1) ? 0 : gap_cnt + 1;
         io_refresh <= (gap_cnt == 0);
      end
   end

   // ------------------------------------------------------------
   // host copy of the transfer input words
   // ------------------------------------------------------------
   // words settle one cycle after the refresh edge, so take them then
   always @(posedge clk_sys) begin
      refresh_d <= io_refresh;
      if (refresh_d) begin
         host_in_first  <= in_first_word;
         host_in_second <= in_second_word;
      end
   end
endmodule
`default_nettype wire

// ---- tb/test_motion_unit_status_exchange.sv ----
`default_nettype none
module test_motion_unit_status_exchange;
   timeunit 1ns;
   timeprecision 1ps;
   import mse_pkg::*;

   logic        clk_sys = 1'b0, rst = 1'b1, ce = 1'b1;
   mse_axis_t   axis2 = '0, axis3 = '0;
   logic [4:0]  task_error = 5'h00;
   logic        battery_low = 1'b0;
   logic [7:0]  indicator_mode = 8'h00;
   logic        fetch_cmd = 1'b0, post_cmd = 1'b0;
   logic [7:0]  fetch_addr = 8'h00, post_addr = 8'h00;
   logic        unit_cmd_pending, io_refresh;
   logic [15:0] out_first = 16'h0000, out_second = 16'h0000;
   logic [15:0] axis23_word, task_unit_word, in_first_word, in_second_word;
   logic        blk_rd = 1'b0, blk_wr = 1'b0, blk_wvalid = 1'b0;
   logic [7:0]  blk_start = 8'h00, blk_count = 8'h00;
   logic [15:0] blk_wdata = 16'h0000;
   logic        block_busy, block_rvalid, xfer_error;
   logic [15:0] block_rdata, host_in_first, host_in_second;
   logic [15:0] exp_mem [256];
   int          n_errors = 0, checks_done = 0, cycles = 0;

   always #2 clk_sys = ~clk_sys;

   mse_bank mse_bank_inst (.clk_sys(clk_sys), .rst(rst), .ce(ce), .axis2(axis2), .axis3(axis3),
      .task_error(task_error), .battery_low(battery_low), .indicator_mode(indicator_mode),
      .unit_fetch_command(fetch_cmd), .unit_post_command(post_cmd), .fetch_var_addr(fetch_addr),
      .post_var_addr(post_addr), .unit_cmd_pending(unit_cmd_pending), .io_refresh(io_refresh),
      .host_out_first(out_first), .host_out_second(out_second), .axis23_word(axis23_word),
      .task_unit_word(task_unit_word), .in_first_word(in_first_word), .in_second_word(in_second_word),
      .host_block_read(blk_rd), .host_block_write(blk_wr), .block_start(blk_start),
      .block_count(blk_count), .block_wvalid(blk_wvalid), .block_wdata(blk_wdata),
      .block_busy(block_busy), .block_rvalid(block_rvalid), .block_rdata(block_rdata),
      .xfer_error(xfer_error));

   mse_host_model mse_host_model_inst (.clk_sys(clk_sys), .rst(rst), .io_refresh(io_refresh),
      .in_first_word(in_first_word), .in_second_word(in_second_word),
      .host_in_first(host_in_first), .host_in_second(host_in_second));

   // ------------------------------------------------------------
   // helpers
   // ------------------------------------------------------------
   task automatic tally_and_finish();
      $display("checks %0d errors %0d", checks_done, n_errors);
      if (n_errors == 0 && checks_done > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask

   task automatic check16(input logic [15:0] got, input logic [15:0] exp, input string what);
      checks_done++;
      if (got !== exp) begin
         n_errors++;
         $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask

   // returns at the second falling edge after a refresh has been taken
   task automatic wait_refresh();
      int i;
      // let the stimulus of this falling edge reach a rising edge first
      @(posedge clk_sys);
      for (i = 0; i < 20 && io_refresh !== 1'b1; i++) @(posedge clk_sys);
      @(posedge clk_sys);
      @(negedge clk_sys);
   endtask

   task automatic start_block(input logic rd, input logic [7:0] st, input logic [7:0] cnt);
      @(negedge clk_sys);
      blk_rd    = rd;
      blk_wr    = ~rd;
      blk_start = st;
      blk_count = cnt;
      @(negedge clk_sys);
      blk_rd = 1'b0;
      blk_wr = 1'b0;
   endtask

   task automatic block_write(input logic [7:0] st, input int cnt);
      int k;
      start_block(1'b0, st, cnt[7:0]);
      for (k = 0; k < cnt; k++) begin
         blk_wvalid = 1'b1;
         blk_wdata  = 16'h5a00 + k[15:0];
         exp_mem[st + k[7:0]] = blk_wdata;
         @(negedge clk_sys);
      end
      blk_wvalid = 1'b0;
      for (k = 0; k < 10 && block_busy !== 1'b0; k++) @(negedge clk_sys);
      check16({15'h0, block_busy}, 16'h0000, "write block still busy");
   endtask

   task automatic block_read(input logic [7:0] st, input int cnt);
      int k, i;
      k = 0;
      start_block(1'b1, st, cnt[7:0]);
      for (i = 0; i < cnt + 10 && k < cnt; i++) begin
         if (block_rvalid === 1'b1) begin
            check16(block_rdata, exp_mem[st + k[7:0]], "block read data");
            k++;
         end
         @(negedge clk_sys);
      end
      check16(k[15:0], cnt[15:0], "block read word count");
   endtask

   always @(posedge clk_sys) begin
      cycles <= cycles + 1;
      if (cycles == 4000) begin
         n_errors++;
         $display("[FAIL] %0t run did not finish in time", $time);
         tally_and_finish();
      end
   end

   // ------------------------------------------------------------
   // test sequence
   // ------------------------------------------------------------
   initial begin
      int b;
      repeat (10) @(negedge clk_sys);
      rst = 1'b0;
      check16(axis23_word | task_unit_word | in_first_word | in_second_word, 16'h0000, "reset words");
      for (b = 0; b < AXIS_FLAGS; b++) begin
         axis2 = mse_axis_t'(8'h01 << b);
         axis3 = mse_axis_t'(8'h80 >> b);
         wait_refresh();
         check16(axis23_word, {8'h80 >> b, 8'h01 << b}, "axis flags");
      end
      ce    = 1'b0;
      axis2 = mse_axis_t'(8'hff);
      wait_refresh();
      check16(axis23_word, 16'h0180, "word frozen while disabled");
      ce    = 1'b1;
      task_error     = 5'h15;
      battery_low    = 1'b1;
      indicator_mode = 8'ha5;
      wait_refresh();
      check16(task_unit_word, 16'ha535, "task and unit word");
      task_error  = 5'h0a;
      battery_low = 1'b0;
      wait_refresh();
      check16(task_unit_word, 16'ha50a, "task word follows sources");
      block_write(8'h00, 128);
      out_first  = 16'h1234;
      out_second = 16'habcd;
      @(negedge clk_sys);
      fetch_cmd  = 1'b1;
      fetch_addr = 8'h10;
      post_cmd   = 1'b1;
      post_addr  = 8'h20;
      @(negedge clk_sys);
      fetch_cmd = 1'b0;
      post_cmd  = 1'b0;
      check16({15'h0, unit_cmd_pending}, 16'h0001, "command waits for refresh");
      exp_mem[8'h10] = 16'h1234;
      exp_mem[8'h11] = 16'habcd;
      wait_refresh();
      repeat (6) @(negedge clk_sys);
      check16({15'h0, unit_cmd_pending}, 16'h0000, "command done after refresh");
      wait_refresh();
      check16(in_first_word, exp_mem[8'h20], "first input word");
      check16(in_second_word, exp_mem[8'h21], "second input word");
      wait_refresh();
      check16(host_in_first, exp_mem[8'h20], "host first copy agrees");
      check16(host_in_second, exp_mem[8'h21], "host copy agrees");
      block_read(8'h00, 128);
      start_block(1'b1, 8'h00, 8'h00);
      @(negedge clk_sys);
      check16({15'h0, xfer_error}, 16'h0001, "zero count refused");
      wait_refresh();
      check16(task_unit_word, 16'ha58a, "transfer error flag");
      block_write(8'hff, 1);
      check16({15'h0, xfer_error}, 16'h0000, "error cleared by good write");
      start_block(1'b0, 8'h00, 8'h81);
      @(negedge clk_sys);
      check16({14'h0, xfer_error, block_busy}, 16'h0002, "oversize block refused");
      block_read(8'hff, 1);
      check16({15'h0, xfer_error}, 16'h0000, "error cleared by good block");
      tally_and_finish();
   end
endmodule
`default_nettype wire
